// ===== verilog/mts_pkg.sv
// constants for the torque limit and speed select block
package mts_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_AGAIN     = 12'h004;
  localparam logic [11:0] OFS_AOFFS     = 12'h008;
  localparam logic [11:0] OFS_AMAX      = 12'h00c;
  localparam logic [11:0] OFS_STATUS    = 12'h010;
  localparam logic [11:0] OFS_DATA_BASE = 12'h100;
  localparam logic [11:0] OFS_DATA_END  = 12'h17c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_DIR_BIT  = 0;
  localparam int CTRL_SRC_LSB  = 1;
  localparam int CTRL_RSET_BIT = 3;
  localparam int CTRL_MAP_LSB  = 4;
  localparam int DS_TQ_LSB     = 16;
  localparam int DS_DEC_LSB    = 8;
  localparam int ST_TQ_LSB     = 12;
  localparam int ST_EN_BIT     = 21;
  localparam int ST_HIT_BIT    = 22;
  localparam int ST_RUN_BIT    = 23;
  localparam int ST_DIR_BIT    = 24;
  localparam int ST_SEL_LSB    = 25;

  // ----------------------------------------------------------------
  // command source selection values
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_DIGITAL    = 2'h0;
  localparam logic [1:0] SRC_SPEED_NO1  = 2'h1;
  localparam logic [1:0] SRC_SPEED_ALL  = 2'h2;
  localparam logic [1:0] SRC_TORQUE_ANA = 2'h3;
  localparam logic [3:0] DATA_NO1       = 4'h1;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic       RST_DIR_CW = 1'h1;
  localparam logic [8:0] RST_AGAIN  = 9'h041;
  localparam logic [8:0] RST_AOFFS  = 9'h000;
  localparam logic [8:0] RST_AMAX   = 9'h12c;
  localparam logic [11:0] RST_SPEED = 12'h032;
  localparam logic [8:0] RST_TQ     = 9'h12c;
  localparam logic [7:0] RST_RAMP   = 8'h05;

  // ----------------------------------------------------------------
  // scaling and timing
  // ----------------------------------------------------------------
  localparam logic [8:0]  TQ_MAX_INST   = 9'h12c;
  localparam logic [11:0] RATED_RPM     = 12'hbb8;
  localparam int          MV_PER_VOLT   = 1000;
  localparam int          MS_PER_TENTH  = 100;
  localparam int          FRAC_BITS     = 16;
  localparam int          CLK_PERIOD_NS = 40;
  localparam int          RAMP_TICK_NS  = 1000000;
  localparam int          BLINK_NS      = 500000000;
  localparam int          RAMP_TICK_CYC = RAMP_TICK_NS / CLK_PERIOD_NS;
  localparam int          BLINK_CYC     = BLINK_NS / CLK_PERIOD_NS;

endpackage

// ===== verilog/mts_torque_speed.sv
// torque limiting, operation data select and speed ramp with apb registers
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ns

module mts_torque_speed
  import mts_pkg::*;
#(
  parameter int RAMP_TICK = RAMP_TICK_CYC,
  parameter int BLINK_TICK = BLINK_CYC
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // input terminals
  input  wire logic        forward_run_input,
  input  wire logic        reverse_run_input,
  input  wire logic        data_select_bit_zero,
  input  wire logic        data_select_bit_one,
  input  wire logic        data_select_bit_two,
  input  wire logic        data_select_bit_three,
  input  wire logic [3:0]  torque_limit_gate_input,
  // analog front end and motor feedback
  input  wire logic [13:0] analog_limit_mv,
  input  wire logic [11:0] analog_speed_rpm,
  input  wire logic [8:0]  motor_torque_pct,
  // local panel
  input  wire logic        panel_local,
  input  wire logic        panel_run,
  input  wire logic        panel_dir_key,
  // motor command, status and panel display outputs
  output logic [11:0]      speed_cmd,
  output logic [8:0]       torque_cap,
  output logic             torque_limit_enable,
  output logic             torque_limit_reached_output,
  output logic             rotate_cw,
  output logic             running,
  output logic             panel_dir_show,
  output logic             panel_dir_is_rev
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic logic [8:0] analog_limit(input logic [13:0] mv,
      input logic [8:0] gain, input logic [8:0] offs, input logic [8:0] mx);
    logic [22:0]        prod;
    logic signed [15:0] sum;
    prod = 23'(gain) * 23'(mv);
    sum  = 16'(prod / 23'(MV_PER_VOLT)) + 16'($signed(offs));
    if (sum < 16'sh0000)
      analog_limit = 9'h000;
    else if (sum > $signed({7'h00, mx}))
      analog_limit = mx;
    else
      analog_limit = sum[8:0];
  endfunction

  function automatic logic [27:0] ramp_step(input logic [11:0] ref_rpm,
      input logic [7:0] tenths);
    logic [27:0] den;
    den = 28'(tenths) * 28'(MS_PER_TENTH);
    if (tenths == 8'h00)
      ramp_step = {RATED_RPM, 16'h0000};
    else if (ref_rpm == 12'h000)
      ramp_step = 28'h0000001;
    else
      ramp_step = {ref_rpm, 16'h0000} / den;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic        dir_cw_q;
  logic [1:0]  src_q;
  logic        ramp_set_q;
  logic [3:0]  gate_map_q;
  logic [8:0]  again_q;
  logic [8:0]  aoffs_q;
  logic [8:0]  amax_q;
  logic [11:0] ds_speed_q [16];
  logic [8:0]  ds_tq_q    [16];
  logic [7:0]  ds_acc_q   [16];
  logic [7:0]  ds_dec_q   [16];

  logic        wr_en;
  logic        rd_en;
  logic        in_data;
  logic [3:0]  data_idx;
  logic        mapped;
  logic [31:0] rd_val;
  logic [31:0] status_w;

  assign wr_en    = psel & penable & pready & pwrite;
  assign rd_en    = psel & ~penable;
  assign in_data  = paddr >= OFS_DATA_BASE && paddr <= OFS_DATA_END;
  assign data_idx = 4'(paddr[11:3] - OFS_DATA_BASE[11:3]);

  // writes take effect at the access edge only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_cw_q   <= RST_DIR_CW;
      src_q      <= SRC_DIGITAL;
      ramp_set_q <= 1'b0;
      gate_map_q <= 4'h0;
      again_q    <= RST_AGAIN;
      aoffs_q    <= RST_AOFFS;
      amax_q     <= RST_AMAX;
    end else if (wr_en && !pslverr) begin
      unique case (paddr)
        OFS_CTRL: begin
          dir_cw_q   <= pwdata[CTRL_DIR_BIT];
          src_q      <= pwdata[CTRL_SRC_LSB +: 2];
          ramp_set_q <= pwdata[CTRL_RSET_BIT];
          gate_map_q <= pwdata[CTRL_MAP_LSB +: 4];
        end
        OFS_AGAIN: again_q <= pwdata[8:0];
        OFS_AOFFS: aoffs_q <= pwdata[8:0];
        OFS_AMAX:  amax_q  <= pwdata[8:0];
        default: ;
      endcase
    end
  end

  // operation data sets, two words each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 16; i++) begin
        ds_speed_q[i] <= RST_SPEED;
        ds_tq_q[i]    <= RST_TQ;
        ds_acc_q[i]   <= RST_RAMP;
        ds_dec_q[i]   <= RST_RAMP;
      end
    end else if (wr_en && in_data && !pslverr) begin
      if (!paddr[2]) begin
        ds_speed_q[data_idx] <= pwdata[11:0];
        ds_tq_q[data_idx]    <= pwdata[DS_TQ_LSB +: 9];
      end else begin
        ds_acc_q[data_idx] <= pwdata[7:0];
        ds_dec_q[data_idx] <= pwdata[DS_DEC_LSB +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // apb read path, one wait-free access phase
  // ----------------------------------------------------------------
  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0000_0000;
    if (in_data && !paddr[2])
      rd_val = {7'h00, ds_tq_q[data_idx], 4'h0, ds_speed_q[data_idx]};
    else if (in_data)
      rd_val = {16'h0000, ds_dec_q[data_idx], ds_acc_q[data_idx]};
    else if (paddr == OFS_CTRL)
      rd_val = {24'h0, gate_map_q, ramp_set_q, src_q, dir_cw_q};
    else if (paddr == OFS_AGAIN)
      rd_val = {23'h0, again_q};
    else if (paddr == OFS_AOFFS)
      rd_val = {23'h0, aoffs_q};
    else if (paddr == OFS_AMAX)
      rd_val = {23'h0, amax_q};
    else if (paddr == OFS_STATUS)
      rd_val = status_w;
    else
      mapped = 1'b0;
    if (paddr[1:0] != 2'h0)
      mapped = 1'b0;
  end

  // the answer is prepared in setup so the access phase ends at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= rd_en;
      pslverr <= rd_en & ~mapped;
      if (rd_en)
        prdata <= (mapped && !pwrite) ? rd_val : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // data selection and torque limit
  // ----------------------------------------------------------------
  logic [3:0]  sel;
  logic        gate_on;
  logic        fwd_on;
  logic        rev_on;
  logic [8:0]  sel_limit;
  logic [11:0] sel_speed;
  logic [8:0]  cap_d;

  assign sel = {data_select_bit_three, data_select_bit_two,
                data_select_bit_one, data_select_bit_zero};
  // an unmapped terminal reads as on so an empty map is always on
  assign gate_on = &(torque_limit_gate_input | ~gate_map_q);
  assign sel_limit = (src_q == SRC_TORQUE_ANA)
                   ? analog_limit(analog_limit_mv, again_q, aoffs_q,
                                  amax_q)
                   : ds_tq_q[sel];
  assign sel_speed = (src_q == SRC_SPEED_ALL ||
                     (src_q == SRC_SPEED_NO1 && sel == DATA_NO1))
                   ? analog_speed_rpm : ds_speed_q[sel];
  assign cap_d = gate_on ? sel_limit : TQ_MAX_INST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      torque_cap                  <= TQ_MAX_INST;
      torque_limit_enable         <= 1'b0;
      torque_limit_reached_output <= 1'b0;
    end else begin
      torque_cap          <= cap_d;
      torque_limit_enable <= gate_on;
      torque_limit_reached_output <= gate_on &&
                                     motor_torque_pct >= cap_d;
    end
  end

  // ----------------------------------------------------------------
  // run demand, direction and local panel
  // ----------------------------------------------------------------
  logic        panel_rev_q;
  logic        demand;
  logic        want_cw;
  logic        stopped;
  logic [27:0] speed_fx_q;
  logic [31:0] blink_cnt_q;

  assign stopped = speed_fx_q == 28'h0000000;
  // in remote both inputs on means stop; direction from the parameter
  assign fwd_on = panel_local ? panel_run & ~panel_rev_q
                              : forward_run_input & ~reverse_run_input;
  assign rev_on = panel_local ? panel_run & panel_rev_q
                              : reverse_run_input & ~forward_run_input;
  assign demand  = fwd_on | rev_on;
  assign want_cw = fwd_on ? dir_cw_q : ~dir_cw_q;

  // the key only flips direction at standstill to avoid plugging
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      panel_rev_q <= 1'b0;
    else if (panel_local && stopped && panel_dir_key)
      panel_rev_q <= ~panel_rev_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_q    <= 32'h0000_0000;
      panel_dir_show <= 1'b0;
    end else if (!(panel_local && stopped)) begin
      blink_cnt_q    <= 32'h0000_0000;
      panel_dir_show <= panel_local;
    end else if (blink_cnt_q == 32'(BLINK_TICK - 1)) begin
      blink_cnt_q    <= 32'h0000_0000;
      panel_dir_show <= ~panel_dir_show;
    end else begin
      blink_cnt_q <= blink_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      panel_dir_is_rev <= 1'b0;
    else
      panel_dir_is_rev <= panel_rev_q;
  end

  // ----------------------------------------------------------------
  // speed ramp, one step per millisecond tick
  // ----------------------------------------------------------------
  logic [31:0] tick_cnt_q;
  logic        tick;
  logic        rev_pending;
  logic [11:0] target;
  logic [27:0] target_fx;
  logic [11:0] ramp_ref;
  logic [27:0] step;

  assign tick = tick_cnt_q == 32'(RAMP_TICK - 1);
  // a reversal first brings the motor to rest in the old direction
  assign rev_pending = demand && !stopped && want_cw != rotate_cw;
  assign target = (demand && !rev_pending) ? sel_speed : 12'h000;
  assign target_fx = {target, 16'h0000};
  assign ramp_ref = ramp_set_q ? ds_speed_q[sel] : RATED_RPM;
  assign step = ramp_step(ramp_ref, (target_fx > speed_fx_q)
                          ? ds_acc_q[sel] : ds_dec_q[sel]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      tick_cnt_q <= 32'h0000_0000;
    else if (tick)
      tick_cnt_q <= 32'h0000_0000;
    else
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      speed_fx_q <= 28'h0000000;
    else if (tick && target_fx > speed_fx_q)
      speed_fx_q <= (target_fx - speed_fx_q > step)
                  ? speed_fx_q + step : target_fx;
    else if (tick && target_fx < speed_fx_q)
      speed_fx_q <= (speed_fx_q - target_fx > step)
                  ? speed_fx_q - step : target_fx;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      rotate_cw <= RST_DIR_CW;
    else if (stopped && demand)
      rotate_cw <= want_cw;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_cmd <= 12'h000;
      running   <= 1'b0;
    end else begin
      speed_cmd <= speed_fx_q[27:FRAC_BITS];
      running   <= !stopped;
    end
  end

  assign status_w = {3'h0, sel, rotate_cw, running,
                     torque_limit_reached_output, torque_limit_enable,
                     torque_cap, speed_cmd};

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_gate_cap;
    gate_on && src_q != SRC_TORQUE_ANA |=> torque_cap == $past(ds_tq_q[sel]);
  endproperty
  a_gate_cap: assert property (p_gate_cap)
    else $error("gate on but cap is not the selected limit");

  property p_gate_off;
    !gate_on |=> torque_cap == TQ_MAX_INST && !torque_limit_enable;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("gate off but torque still limited");

  property p_unmapped;
    gate_map_q == 4'h0 |=> torque_limit_enable;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped gate not treated as on");

  property p_and;
    (torque_limit_gate_input & gate_map_q) != gate_map_q
      |=> !torque_limit_enable;
  endproperty
  a_and: assert property (p_and)
    else $error("gate on with a mapped terminal off");

  // reached must track the cap and torque seen one edge earlier, both ways
  property p_reached;
    torque_limit_reached_output ==
      (torque_limit_enable && $past(motor_torque_pct) >= torque_cap);
  endproperty
  a_reached: assert property (p_reached)
    else $error("reached output missing at the limit");

  property p_amax;
    src_q == SRC_TORQUE_ANA && gate_on |=> torque_cap <= $past(amax_q);
  endproperty
  a_amax: assert property (p_amax)
    else $error("analog limit above its maximum");

  property p_both_stop;
    !panel_local && forward_run_input && reverse_run_input
      |-> target == 12'h000;
  endproperty
  a_both_stop: assert property (p_both_stop)
    else $error("both run inputs on but speed demanded");

  property p_dir;
    stopped && !panel_local && forward_run_input && !reverse_run_input
      |=> rotate_cw == $past(dir_cw_q);
  endproperty
  a_dir: assert property (p_dir)
    else $error("forward direction not set by the parameter");

  property p_ramp_bound;
    tick ##1 !tick [*2] |-> $stable(speed_fx_q);
  endproperty
  a_ramp_bound: assert property (p_ramp_bound)
    else $error("speed moved between ramp ticks");

endmodule

// ===== verif/mts_switch_model.sv
// controller model driving the run terminals with a direction gap
`timescale 1ns/1ns

module mts_switch_model #(
  parameter int GAP_CYC = 250000
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // requests from the bench
  input  wire logic want_fwd,
  input  wire logic want_rev,
  // run terminals
  output logic      fwd_run,
  output logic      rev_run
);

  // ----------------------------------------------------------------
  // interlock
  // ----------------------------------------------------------------
  // any release starts a quiet gap; no run input rises after the release edge until it ends,
  // but a reversal requested in the release cycle rises on that same edge with no gap
  int unsigned gap_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q   <= 0;
      fwd_run <= 1'h0;
      rev_run <= 1'h0;
    end else begin
      if ((fwd_run && !want_fwd) || (rev_run && !want_rev)) begin
        gap_q <= GAP_CYC;
      end else if (gap_q != 0) begin
        gap_q <= gap_q - 1;
      end
      fwd_run <= want_fwd && (fwd_run || gap_q == 0);
      rev_run <= want_rev && (rev_run || gap_q == 0);
    end
  end

endmodule

// ===== verif/mts_torque_speed_test.sv
// self-checking bench for the torque limit and speed select block
`timescale 1ns/1ns

module mts_torque_speed_test;
  import mts_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, speed_cmd, analog_speed_rpm;
  logic [31:0] pwdata, prdata, rdat;
  logic forward_run_input, reverse_run_input, want_fwd, want_rev;
  logic data_select_bit_zero, data_select_bit_one;
  logic data_select_bit_two, data_select_bit_three;
  logic [3:0] torque_limit_gate_input;
  logic [13:0] analog_limit_mv;
  logic [8:0] motor_torque_pct, torque_cap;
  logic panel_local, panel_run, panel_dir_key, rerr;
  logic torque_limit_enable, torque_limit_reached_output, rotate_cw;
  logic running, panel_dir_show, panel_dir_is_rev, show0;
  int bad_count, total_checks, cyc;

  mts_torque_speed #(.RAMP_TICK(10), .BLINK_TICK(8)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .forward_run_input, .reverse_run_input,
    .data_select_bit_zero, .data_select_bit_one, .data_select_bit_two,
    .data_select_bit_three, .torque_limit_gate_input, .analog_limit_mv,
    .analog_speed_rpm, .motor_torque_pct, .panel_local, .panel_run,
    .panel_dir_key, .speed_cmd, .torque_cap, .torque_limit_enable,
    .torque_limit_reached_output, .rotate_cw, .running, .panel_dir_show,
    .panel_dir_is_rev);

  mts_switch_model #(.GAP_CYC(20)) ctl (
    .pclk, .presetn, .want_fwd, .want_rev,
    .fwd_run(forward_run_input), .rev_run(reverse_run_input));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task finish_test();
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task check_val(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask

  // entered just after a rising edge; leaves one idle edge behind it
  task apb_xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
                output logic [31:0] r, output logic e);
    int n;
    n = 0;
    psel <= 1'h1; penable <= 1'h0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    r = prdata;
    e = pslverr;
    if (n >= 50) bad_count++;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb_xfer(a, 1'h1, d, rdat, rerr);
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    apb_xfer(a, 1'h0, 32'h0, rdat, rerr);
    check_val(rdat, exp);
    check_val({31'h0, rerr}, {31'h0, ee});
  endtask

  task settle();
    repeat (3) @(posedge pclk);
  endtask

  task sel(input logic [3:0] n);
    {data_select_bit_three, data_select_bit_two} <= n[3:2];
    {data_select_bit_one, data_select_bit_zero} <= n[1:0];
    settle();
  endtask

  // bounded wait for the ramp to land on a value, then compare it
  task wait_speed(input logic [11:0] v);
    int n;
    n = 0;
    while (speed_cmd !== v && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    check_val({20'h0, speed_cmd}, {20'h0, v});
  endtask

  // ----------------------------------------------------------------
  // clock, reset, timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      finish_test();
    end
  end

  initial begin
    presetn = 1'h0; psel = 1'h0; penable = 1'h0; pwrite = 1'h0;
    paddr = 12'h0; pwdata = 32'h0; want_fwd = 1'h0; want_rev = 1'h0;
    {data_select_bit_three, data_select_bit_two} = 2'h0;
    {data_select_bit_one, data_select_bit_zero} = 2'h0;
    torque_limit_gate_input = 4'h0; analog_limit_mv = 14'h0;
    analog_speed_rpm = 12'h0; motor_torque_pct = 9'h0;
    panel_local = 1'h0; panel_run = 1'h0; panel_dir_key = 1'h0;
    bad_count = 0; total_checks = 0; cyc = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    // reset values and an unmapped place
    rd_chk(OFS_CTRL, 32'h1, 1'h0);
    rd_chk(OFS_AGAIN, 32'h41, 1'h0);
    rd_chk(OFS_AOFFS, 32'h0, 1'h0);
    rd_chk(OFS_AMAX, 32'h12c, 1'h0);
    rd_chk(OFS_DATA_BASE, 32'h012c0032, 1'h0);
    rd_chk(OFS_DATA_BASE + 12'h004, 32'h505, 1'h0);
    rd_chk(12'h020, 32'h0, 1'h1);
    // gate unmapped counts as on, data set 2 limit applies
    wr(OFS_DATA_BASE + 12'h010, 32'h006403e8);
    wr(OFS_DATA_BASE + 12'h014, 32'h0);
    wr(OFS_DATA_BASE + 12'h018, 32'h012c07d0);
    wr(OFS_DATA_BASE + 12'h01c, 32'h0);
    sel(4'h2);
    check_val({31'h0, torque_limit_enable}, 32'h1);
    check_val({23'h0, torque_cap}, 32'h64);
    apb_xfer(OFS_STATUS, 1'h0, 32'h0, rdat, rerr);
    check_val({28'h0, rdat[28:25]}, 32'h2);
    // gate mapped to terminals 0 and 2, ANDed
    wr(OFS_CTRL, 32'h51);
    torque_limit_gate_input <= 4'h1;
    motor_torque_pct <= 9'h064;
    settle();
    check_val({31'h0, torque_limit_enable}, 32'h0);
    check_val({23'h0, torque_cap}, 32'h12c);
    check_val({31'h0, torque_limit_reached_output}, 32'h0);
    torque_limit_gate_input <= 4'h5;
    settle();
    check_val({23'h0, torque_cap}, 32'h64);
    check_val({31'h0, torque_limit_reached_output}, 32'h1);
    motor_torque_pct <= 9'h063;
    settle();
    check_val({31'h0, torque_limit_reached_output}, 32'h0);
    // analog limit: gain, offset, clamp
    wr(OFS_CTRL, 32'h57);
    wr(OFS_AGAIN, 32'h1e);
    wr(OFS_AOFFS, 32'ha);
    analog_limit_mv <= 14'h1388;
    settle();
    check_val({23'h0, torque_cap}, 32'ha0);
    wr(OFS_AMAX, 32'h78);
    settle();
    check_val({23'h0, torque_cap}, 32'h78);
    wr(OFS_AOFFS, 32'h1ce);
    analog_limit_mv <= 14'h3e8;
    settle();
    check_val({23'h0, torque_cap}, 32'h0);
    // run, change data while running, stop, both on, reverse
    wr(OFS_CTRL, 32'h1);
    want_fwd <= 1'h1;
    wait_speed(12'h3e8);
    check_val({31'h0, rotate_cw}, 32'h1);
    sel(4'h3);
    wait_speed(12'h7d0);
    want_fwd <= 1'h0;
    wait_speed(12'h0);
    settle();
    check_val({31'h0, running}, 32'h0);
    {want_fwd, want_rev} <= 2'h3;
    repeat (60) @(posedge pclk);
    check_val({20'h0, speed_cmd}, 32'h0);
    {want_fwd, want_rev} <= 2'h0;
    repeat (30) @(posedge pclk);
    want_rev <= 1'h1;
    wait_speed(12'h7d0);
    check_val({31'h0, rotate_cw}, 32'h0);
    want_rev <= 1'h0;
    wait_speed(12'h0);
    repeat (30) @(posedge pclk);
    wr(OFS_CTRL, 32'h0);
    want_fwd <= 1'h1;
    wait_speed(12'h7d0);
    check_val({31'h0, rotate_cw}, 32'h0);
    want_fwd <= 1'h0;
    wait_speed(12'h0);
    repeat (30) @(posedge pclk);
    // analog speed sources
    wr(OFS_CTRL, 32'h5);
    analog_speed_rpm <= 12'h4d2;
    want_fwd <= 1'h1;
    wait_speed(12'h4d2);
    wr(OFS_CTRL, 32'h3);
    wait_speed(12'h7d0);
    sel(4'h1);
    wait_speed(12'h4d2);
    want_fwd <= 1'h0;
    wait_speed(12'h0);
    repeat (30) @(posedge pclk);
    // default ramp of 0.5 s against 3000 r/min: 6 per tick
    wr(OFS_CTRL, 32'h1);
    sel(4'h0);
    want_fwd <= 1'h1;
    wait_speed(12'h6);
    wait_speed(12'h32);
    want_fwd <= 1'h0;
    wait_speed(12'h0);
    // ramp time against the set speed: 1000 r/min in 0.1 s, 10 per tick
    wr(OFS_CTRL, 32'h9);
    wr(OFS_DATA_BASE + 12'h014, 32'h0101);
    sel(4'h2);
    want_fwd <= 1'h1;
    wait_speed(12'ha);
    wait_speed(12'h3e8);
    want_fwd <= 1'h0;
    wait_speed(12'h0);
    // panel: blink at standstill, key toggles direction
    panel_local <= 1'h1;
    settle();
    show0 = panel_dir_show;
    repeat (9) @(posedge pclk);
    check_val({31'h0, panel_dir_show}, {31'h0, ~show0});
    check_val({31'h0, panel_dir_is_rev}, 32'h0);
    panel_dir_key <= 1'h1;
    @(posedge pclk);
    panel_dir_key <= 1'h0;
    settle();
    check_val({31'h0, panel_dir_is_rev}, 32'h1);
    // panel run in the toggled direction, display steady while moving
    panel_run <= 1'h1;
    wait_speed(12'h3e8);
    check_val({31'h0, rotate_cw}, 32'h0);
    check_val({31'h0, panel_dir_show}, 32'h1);
    panel_run <= 1'h0;
    wait_speed(12'h0);
    finish_test();
  end

endmodule
